/* shared/cwfd_pkg.sv */
// Constants and types for the configuration word field decoder
package cwfd_pkg;

  // ----------------------------------------------------------------
  // Word indices and load values
  // ----------------------------------------------------------------
  localparam logic [1:0]  IDX_WDOG   = 2'h0;
  localparam logic [1:0]  IDX_OSC    = 2'h1;
  localparam logic [1:0]  IDX_PROT   = 2'h2;
  localparam logic [1:0]  IDX_LAST   = 2'h2;
  localparam logic [23:0] UPPER_ONES = 24'hff0000;
  localparam logic [23:0] ERASED     = 24'hffffff;
  localparam logic [7:0]  UPPER_READ = 8'hff;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int B_PRESCALE    = 4;
  localparam int B_WIN_DISABLE = 5;
  localparam int L_POSTSCALE   = 0;
  localparam int B_TWO_SPEED   = 15;
  localparam int B_BACKUP_BOR  = 14;
  localparam int B_CLK_MUX_EN  = 13;
  localparam int B_ALT_CMP_REF = 12;
  localparam int B_ALT_CNV_REF = 11;
  localparam int L_INIT_OSC    = 8;
  localparam int L_CLK_SWITCH  = 6;
  localparam int B_OSC_OUT     = 5;
  localparam int L_WDOG_CLK    = 3;
  localparam int L_PRIM_MODE   = 0;
  localparam int B_END_PAGE    = 15;
  localparam int B_CFG_PAGE    = 14;
  localparam int B_SEG_DISABLE = 13;
  localparam int B_BOR_EN      = 12;
  localparam int L_WIN_WIDTH   = 9;
  localparam int B_SEC_CIRCUIT = 8;
  localparam int L_BOUNDARY    = 0;

  // ----------------------------------------------------------------
  // Window widths in eighths of the period, and page zero
  // ----------------------------------------------------------------
  localparam logic [2:0] WIN_25  = 3'h2;
  localparam logic [2:0] WIN_375 = 3'h3;
  localparam logic [2:0] WIN_50  = 3'h4;
  localparam logic [2:0] WIN_75  = 3'h6;
  localparam logic [6:0] PAGE_ZERO = 7'h00;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_WDOG = 12'h000;
  localparam logic [11:0] ADDR_OSC  = 12'h004;
  localparam logic [11:0] ADDR_PROT = 12'h008;
  localparam logic [11:0] ADDR_STAT = 12'h00c;
  localparam logic [11:0] ADDR_CTRL = 12'h010;

  typedef enum logic [1:0] {
    WCLK_SYSTEM, WCLK_LOW_POWER_RC, WCLK_FAST_RC_31K, WCLK_SECONDARY
  } cwfd_wclk_t;

  typedef enum logic [2:0] {
    IOSC_FAST_RC = 3'h0, IOSC_FAST_RC_PLL = 3'h1, IOSC_PRIMARY = 3'h2,
    IOSC_PRIMARY_PLL = 3'h3, IOSC_SECONDARY = 3'h4,
    IOSC_LOW_POWER_RC = 3'h5, IOSC_RESERVED = 3'h6,
    IOSC_FAST_RC_DIV = 3'h7
  } cwfd_iosc_t;

  typedef enum logic [1:0] {
    PMODE_EXT_CLOCK = 2'h0, PMODE_STD_CRYSTAL = 2'h1,
    PMODE_HS_CRYSTAL = 2'h2, PMODE_DISABLED = 2'h3
  } cwfd_pmode_t;

  typedef enum logic { LD_FETCH, LD_DONE } cwfd_ld_t;

  typedef struct packed {
    logic        wdog_prescale_128;
    logic [3:0]  wdog_postscale_log2;
    cwfd_wclk_t  wdog_clock;
    logic        wdog_window_mode;
    logic [2:0]  wdog_window_eighths;
    logic        two_speed_startup_en;
    logic        backup_supply_bor_en;
    logic        alt_cmp_ref_pins;
    logic        alt_dac_ref_pins;
    logic        alt_conv_ref_pins;
    cwfd_iosc_t  initial_osc;
    logic        clock_switch_en;
    logic        fail_safe_monitor_en;
    logic        clock_output_en;
    cwfd_pmode_t primary_osc_mode;
    logic        secondary_osc_crystal_en;
    logic        brownout_reset_en;
    logic        segment_protect_en;
    logic [6:0]  protect_low_page;
    logic [6:0]  protect_high_page;
    logic        config_page_protected;
  } cwfd_cfg_t;

endpackage : cwfd_pkg

/* hdl/cwfd_decoder.sv */
// Configuration word loader, decoder and APB register view
//
// Overview of operation
// - Prescale select set gives 1:128, clear gives 1:32.
// - Four-bit postscale code selects ratio two to the code power.
// - Switchover bit set enables two-speed start-up.
// - Clock mux disabled: watchdog always on low-power RC.
// - Mux codes: 11 low-power, 10 fast/low, 01 secondary, 00 system awake, low-power asleep.
// - Code 10 uses 31 kHz fast RC only windowed, awake, not on LPR.
// - Two bits move reference pins; comparator bit also moves DAC.
// - Three-bit field selects the start-up oscillator; 110 reserved.
// - 1x disables switching and monitor; 01 switching; 00 both.
// - Modes 11/00: out bit picks half-rate clock output or port.
// - Primary mode: 11 off, 10 high-speed, 01 standard, 00 external.
// - End-page set: boundary to last page; clear: zero to boundary.
// - Config page bit clear with protection on protects last page.
// - With protection on, end-page set or boundary at config page protects that page.
// - Disable bit set turns segment protection off.
// - Brown-out reset enable bit turns brown-out reset on.
// - Window width: 11 25%, 10 37.5%, 01 50%, 00 75%.
// - Secondary select set enables crystal, clear takes digital clock.
// - Upper byte reads as ones; reserved bits kept by programmer.
// - All words reload from flash after every reset.
// - Boundary field counts pages of 512 instruction words.
`timescale 1ns/1ns

module cwfd_decoder #(
  parameter logic [6:0] CFG_WORD_PAGE = 7'h55
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   flash_req,
  output logic      [1:0]        flash_word_sel,
  input  wire logic [23:0]       flash_rdata,
  input  wire logic              flash_rvalid,
  input  wire logic              sysclk_is_low_power_rc,
  output logic                   load_done,
  output cwfd_pkg::cwfd_cfg_t    cfg
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cwfd_pkg::cwfd_ld_t  ld_reg, ld_next;
  logic [1:0]          idx_reg, idx_next;
  logic [23:0]         word_reg [3];
  logic [23:0]         word_next [3];
  cwfd_pkg::cwfd_cfg_t cfg_reg, cfg_next;
  logic                sleep_reg, sleep_next;
  logic [31:0]         rdata_reg, rdata_next;
  logic                err_reg, err_next;
  logic [23:0]         w_wdog, w_osc, w_prot;

  assign w_wdog = word_reg[cwfd_pkg::IDX_WDOG];
  assign w_osc  = word_reg[cwfd_pkg::IDX_OSC];
  assign w_prot = word_reg[cwfd_pkg::IDX_PROT];

  // ----------------------------------------------------------------
  // Loader: fetches each word once after reset
  // ----------------------------------------------------------------
  always_comb begin
    ld_next  = ld_reg;
    idx_next = idx_reg;
    for (int i = 0; i < 3; i++) begin
      word_next[i] = word_reg[i];
    end
    if (ld_reg == cwfd_pkg::LD_FETCH && flash_rvalid) begin
      word_next[idx_reg] = flash_rdata | cwfd_pkg::UPPER_ONES;
      if (idx_reg == cwfd_pkg::IDX_LAST) begin
        ld_next = cwfd_pkg::LD_DONE;
      end else begin
        idx_next = idx_reg + 2'h1;
      end
    end
  end

  // Reset returns the words to the erased value and the loader to fetch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_reg  <= cwfd_pkg::LD_FETCH;
      idx_reg <= cwfd_pkg::IDX_WDOG;
      for (int i = 0; i < 3; i++) begin
        word_reg[i] <= cwfd_pkg::ERASED;
      end
    end else begin
      ld_reg  <= ld_next;
      idx_reg <= idx_next;
      for (int i = 0; i < 3; i++) begin
        word_reg[i] <= word_next[i];
      end
    end
  end

  assign flash_req      = (ld_reg == cwfd_pkg::LD_FETCH);
  assign flash_word_sel = idx_reg;
  assign load_done      = (ld_reg == cwfd_pkg::LD_DONE);

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] wclk;
    logic [1:0] win;
    logic [1:0] pm;
    logic [6:0] bnd;
    wclk = w_osc[cwfd_pkg::L_WDOG_CLK +: 2];
    win  = w_prot[cwfd_pkg::L_WIN_WIDTH +: 2];
    pm   = w_osc[cwfd_pkg::L_PRIM_MODE +: 2];
    bnd  = w_prot[cwfd_pkg::L_BOUNDARY +: 7];
    cfg_next = '0;
    cfg_next.wdog_prescale_128 = w_wdog[cwfd_pkg::B_PRESCALE];
    cfg_next.wdog_postscale_log2 =
      w_wdog[cwfd_pkg::L_POSTSCALE +: 4];
    cfg_next.wdog_window_mode = !w_wdog[cwfd_pkg::B_WIN_DISABLE];
    if (!w_osc[cwfd_pkg::B_CLK_MUX_EN]) begin
      cfg_next.wdog_clock = cwfd_pkg::WCLK_LOW_POWER_RC;
    end else begin
      case (wclk)
        2'h3: cfg_next.wdog_clock = cwfd_pkg::WCLK_LOW_POWER_RC;
        2'h2: begin
          if (!w_wdog[cwfd_pkg::B_WIN_DISABLE] && !sleep_reg &&
              !sysclk_is_low_power_rc) begin
            cfg_next.wdog_clock = cwfd_pkg::WCLK_FAST_RC_31K;
          end else begin
            cfg_next.wdog_clock = cwfd_pkg::WCLK_LOW_POWER_RC;
          end
        end
        2'h1: cfg_next.wdog_clock = cwfd_pkg::WCLK_SECONDARY;
        default: begin
          cfg_next.wdog_clock = sleep_reg ? cwfd_pkg::WCLK_LOW_POWER_RC
                                          : cwfd_pkg::WCLK_SYSTEM;
        end
      endcase
    end
    case (win)
      2'h3:    cfg_next.wdog_window_eighths = cwfd_pkg::WIN_25;
      2'h2:    cfg_next.wdog_window_eighths = cwfd_pkg::WIN_375;
      2'h1:    cfg_next.wdog_window_eighths = cwfd_pkg::WIN_50;
      default: cfg_next.wdog_window_eighths = cwfd_pkg::WIN_75;
    endcase
    cfg_next.two_speed_startup_en =
      w_osc[cwfd_pkg::B_TWO_SPEED];
    cfg_next.backup_supply_bor_en =
      w_osc[cwfd_pkg::B_BACKUP_BOR];
    cfg_next.alt_cmp_ref_pins  = w_osc[cwfd_pkg::B_ALT_CMP_REF];
    cfg_next.alt_dac_ref_pins  = w_osc[cwfd_pkg::B_ALT_CMP_REF];
    cfg_next.alt_conv_ref_pins = w_osc[cwfd_pkg::B_ALT_CNV_REF];
    cfg_next.initial_osc = cwfd_pkg::cwfd_iosc_t'(
      w_osc[cwfd_pkg::L_INIT_OSC +: 3]);
    cfg_next.clock_switch_en =
      !w_osc[cwfd_pkg::L_CLK_SWITCH + 1];
    cfg_next.fail_safe_monitor_en =
      w_osc[cwfd_pkg::L_CLK_SWITCH +: 2] == 2'h0;
    cfg_next.primary_osc_mode = cwfd_pkg::cwfd_pmode_t'(pm);
    cfg_next.clock_output_en = (pm == 2'h3 || pm == 2'h0) &&
      w_osc[cwfd_pkg::B_OSC_OUT];
    cfg_next.secondary_osc_crystal_en =
      w_prot[cwfd_pkg::B_SEC_CIRCUIT];
    cfg_next.brownout_reset_en = w_prot[cwfd_pkg::B_BOR_EN];
    cfg_next.segment_protect_en =
      !w_prot[cwfd_pkg::B_SEG_DISABLE];
    if (w_prot[cwfd_pkg::B_END_PAGE]) begin
      cfg_next.protect_low_page  = bnd;
      cfg_next.protect_high_page = CFG_WORD_PAGE;
    end else begin
      cfg_next.protect_low_page  = cwfd_pkg::PAGE_ZERO;
      cfg_next.protect_high_page = bnd;
    end
    cfg_next.config_page_protected = cfg_next.segment_protect_en &&
      (!w_prot[cwfd_pkg::B_CFG_PAGE] ||
       w_prot[cwfd_pkg::B_END_PAGE] || bnd == CFG_WORD_PAGE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= '0;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign cfg = cfg_reg;

  // ----------------------------------------------------------------
  // APB slave: read data captured in the setup cycle
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = rdata_reg;
    err_next   = err_reg;
    sleep_next = sleep_reg;
    if (psel && !penable) begin
      err_next   = 1'b0;
      rdata_next = '0;
      case (paddr)
        cwfd_pkg::ADDR_WDOG: rdata_next[23:0] = w_wdog;
        cwfd_pkg::ADDR_OSC:  rdata_next[23:0] = w_osc;
        cwfd_pkg::ADDR_PROT: rdata_next[23:0] = w_prot;
        cwfd_pkg::ADDR_STAT: rdata_next[0]    = load_done;
        cwfd_pkg::ADDR_CTRL: rdata_next[0]    = sleep_reg;
        default:             err_next         = 1'b1;
      endcase
    end
    if (psel && penable && pwrite && paddr == cwfd_pkg::ADDR_CTRL) begin
      sleep_next = pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= '0;
      err_reg   <= 1'b0;
      sleep_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      err_reg   <= err_next;
      sleep_reg <= sleep_next;
    end
  end

  assign prdata  = rdata_reg;
  assign pready  = 1'b1;
  assign pslverr = err_reg && psel && penable;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking ck @(posedge pclk); endclocking
  default disable iff (!presetn);

  prescale_ratio_a: assert property (
    load_done |->
      cfg_reg.wdog_prescale_128 == $past(w_wdog[cwfd_pkg::B_PRESCALE]))
    else $error("prescale select not decoded");

  postscale_code_a: assert property (
    load_done |-> cfg_reg.wdog_postscale_log2 ==
      $past(w_wdog[cwfd_pkg::L_POSTSCALE +: 4]))
    else $error("postscale code not decoded");

  mux_off_clock_a: assert property (
    !w_osc[cwfd_pkg::B_CLK_MUX_EN] |=>
      cfg_reg.wdog_clock == cwfd_pkg::WCLK_LOW_POWER_RC)
    else $error("watchdog clock not low-power with mux off");

  fast_rc_pick_a: assert property (
    (w_osc[cwfd_pkg::B_CLK_MUX_EN] && w_osc[4:3] == 2'h2 &&
     (sleep_reg || sysclk_is_low_power_rc)) |=>
      cfg_reg.wdog_clock == cwfd_pkg::WCLK_LOW_POWER_RC)
    else $error("fast RC chosen while asleep or on low-power clock");

  switch_monitor_a: assert property (
    w_osc[7] |=> !cfg_reg.clock_switch_en && !cfg_reg.fail_safe_monitor_en)
    else $error("switching left on with code 1x");

  clock_out_a: assert property (
    (w_osc[1:0] == 2'h2 || w_osc[1:0] == 2'h1) |=> !cfg_reg.clock_output_en)
    else $error("clock output in crystal mode");

  low_page_a: assert property (
    !w_prot[cwfd_pkg::B_END_PAGE] |=> cfg_reg.protect_low_page == 7'h00)
    else $error("lower boundary not page zero");

  config_page_a: assert property (
    (!w_prot[cwfd_pkg::B_SEG_DISABLE] && w_prot[cwfd_pkg::B_END_PAGE])
      |=> cfg_reg.config_page_protected)
    else $error("config page left open with end page set");

  window_width_a: assert property (
    w_prot[10:9] == 2'h0 |=> cfg_reg.wdog_window_eighths == 3'h6)
    else $error("window width code 00 not 75 percent");

  upper_ones_a: assert property (
    (psel && penable && paddr == cwfd_pkg::ADDR_OSC) |->
      prdata[23:16] == 8'hff)
    else $error("upper byte of word not ones");

  words_stable_a: assert property (
    load_done |=> load_done && $stable(w_wdog) && $stable(w_prot))
    else $error("configuration changed after load");

  two_speed_a: assert property (
    load_done |-> cfg_reg.two_speed_startup_en ==
      $past(w_osc[cwfd_pkg::B_TWO_SPEED]))
    else $error("two-speed start-up not decoded");

  secondary_src_a: assert property (
    (load_done && w_osc[cwfd_pkg::B_CLK_MUX_EN] &&
     w_osc[cwfd_pkg::L_WDOG_CLK +: 2] == 2'h1) |=>
      cfg_reg.wdog_clock == cwfd_pkg::WCLK_SECONDARY)
    else $error("watchdog clock code 01 not secondary");

  system_src_a: assert property (
    (load_done && w_osc[cwfd_pkg::B_CLK_MUX_EN] && !sleep_reg &&
     w_osc[cwfd_pkg::L_WDOG_CLK +: 2] == 2'h0) |=>
      cfg_reg.wdog_clock == cwfd_pkg::WCLK_SYSTEM)
    else $error("watchdog clock code 00 not system clock");

  sleep_src_a: assert property (
    (load_done && w_osc[cwfd_pkg::B_CLK_MUX_EN] && sleep_reg &&
     w_osc[cwfd_pkg::L_WDOG_CLK +: 2] == 2'h0) |=>
      cfg_reg.wdog_clock == cwfd_pkg::WCLK_LOW_POWER_RC)
    else $error("watchdog clock code 00 not low-power in sleep");

  fast_rc_src_a: assert property (
    (load_done && w_osc[cwfd_pkg::B_CLK_MUX_EN] &&
     w_osc[cwfd_pkg::L_WDOG_CLK +: 2] == 2'h2 &&
     !w_wdog[cwfd_pkg::B_WIN_DISABLE] && !sleep_reg &&
     !sysclk_is_low_power_rc) |=>
      cfg_reg.wdog_clock == cwfd_pkg::WCLK_FAST_RC_31K)
    else $error("fast RC not chosen in windowed mode");

  dac_ref_a: assert property (
    load_done |-> cfg_reg.alt_dac_ref_pins ==
      $past(w_osc[cwfd_pkg::B_ALT_CMP_REF]))
    else $error("DAC reference pins not on comparator bit");

  initial_osc_a: assert property (
    load_done |-> cfg_reg.initial_osc ==
      $past(w_osc[cwfd_pkg::L_INIT_OSC +: 3]))
    else $error("initial oscillator not decoded");

  primary_mode_a: assert property (
    load_done |-> cfg_reg.primary_osc_mode ==
      $past(w_osc[cwfd_pkg::L_PRIM_MODE +: 2]))
    else $error("primary oscillator mode not decoded");

  high_page_a: assert property (
    (load_done && !w_prot[cwfd_pkg::B_END_PAGE]) |=>
      cfg_reg.protect_high_page ==
        $past(w_prot[cwfd_pkg::L_BOUNDARY +: 7]))
    else $error("upper boundary not the boundary page");

  last_page_a: assert property (
    (load_done && w_prot[cwfd_pkg::B_END_PAGE]) |=>
      cfg_reg.protect_high_page == CFG_WORD_PAGE)
    else $error("upper boundary not the last page");

  cfg_page_bit_a: assert property (
    (load_done && !w_prot[cwfd_pkg::B_SEG_DISABLE] &&
     !w_prot[cwfd_pkg::B_CFG_PAGE]) |=> cfg_reg.config_page_protected)
    else $error("config page open with protect bit clear");

  cfg_page_bnd_a: assert property (
    (load_done && !w_prot[cwfd_pkg::B_SEG_DISABLE] &&
     w_prot[cwfd_pkg::L_BOUNDARY +: 7] == CFG_WORD_PAGE) |=>
      cfg_reg.config_page_protected)
    else $error("config page open with boundary on it");

  seg_disable_a: assert property (
    load_done |-> cfg_reg.segment_protect_en ==
      !$past(w_prot[cwfd_pkg::B_SEG_DISABLE]))
    else $error("segment protection enable not decoded");

  bor_enable_a: assert property (
    load_done |-> cfg_reg.brownout_reset_en ==
      $past(w_prot[cwfd_pkg::B_BOR_EN]))
    else $error("brown-out reset enable not decoded");

  window_25_a: assert property (
    (load_done && w_prot[cwfd_pkg::L_WIN_WIDTH +: 2] == 2'h3) |=>
      cfg_reg.wdog_window_eighths == cwfd_pkg::WIN_25)
    else $error("window width code 11 not 25 percent");

  last_word_a: assert property (
    (flash_req && flash_rvalid &&
     flash_word_sel == cwfd_pkg::IDX_LAST) |=> load_done && !flash_req)
    else $error("load not done after last word");

  word_upper_a: assert property (
    (psel && penable && (paddr == cwfd_pkg::ADDR_WDOG ||
     paddr == cwfd_pkg::ADDR_PROT)) |->
      prdata[23:16] == cwfd_pkg::UPPER_READ)
    else $error("upper byte of stored word not ones");

  cfg_fixed_a: assert property (
    (load_done ##1 load_done) |=>
      $stable(cfg_reg.initial_osc) && $stable(cfg_reg.brownout_reset_en) &&
      $stable(cfg_reg.protect_high_page))
    else $error("decoded settings changed after load");

endmodule : cwfd_decoder

/* tb/cwfd_decoder_tb.sv */
// Self-checking bench for the configuration word field decoder
`timescale 1ns/1ns

module cwfd_decoder_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [6:0] CW_PAGE = 7'h55;
  logic                pclk;
  logic                presetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [11:0]         paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                flash_req;
  logic [1:0]          flash_word_sel;
  logic [23:0]         flash_rdata;
  logic                flash_rvalid;
  logic                sysclk_is_low_power_rc;
  logic                load_done;
  cwfd_pkg::cwfd_cfg_t cfg;
  int                  n_errors;
  int                  check_count;
  logic [31:0]         rd;
  logic                er;

  cwfd_decoder #(.CFG_WORD_PAGE(CW_PAGE)) cwfd_decoder_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_req(flash_req),
    .flash_word_sel(flash_word_sel), .flash_rdata(flash_rdata),
    .flash_rvalid(flash_rvalid), .load_done(load_done), .cfg(cfg),
    .sysclk_is_low_power_rc(sysclk_is_low_power_rc));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] seen,
                     input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic final_report;
    if (n_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Reset, then hand the three words over back to back
  task automatic load(input logic [23:0] w0, w1, w2, input int nrst);
    logic [23:0] w [3];
    w = '{w0, w1, w2};
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (nrst - 1) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      @(posedge pclk);
      flash_rvalid <= 1'b1;
      flash_rdata  <= w[k];
      @(negedge pclk);
      chk("flash_word_sel", flash_word_sel, k);
    end
    @(posedge pclk);
    flash_rvalid <= 1'b0;
    @(negedge pclk);
    chk("load_done", load_done, 1);
    chk("flash_req", flash_req, 0);
    @(posedge pclk);
    @(negedge pclk);
  endtask : load

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_sweep;
    logic [23:0] w0, w1, w2;
    logic [1:0]  j;
    logic [2:0]  win [4];
    logic [1:0]  aw [4];
    logic [1:0]  sl [4];
    win = '{cwfd_pkg::WIN_75, cwfd_pkg::WIN_50, cwfd_pkg::WIN_375,
            cwfd_pkg::WIN_25};
    aw = '{2'h0, 2'h3, 2'h2, 2'h1};
    sl = '{2'h1, 2'h3, 2'h1, 2'h1};
    for (int i = 0; i < 8; i++) begin
      j  = i[1:0];
      w0 = {16'h0, 2'h3, 1'b0, i[0], i[2:0], 1'b1};
      w1 = {8'h0, i[0], i[1], 1'b1, i[2], i[1], i[2:0], j, 1'b1, j, 1'b0, j};
      w2 = {8'h0, 2'h0, j[0], 2'h3, j, 2'h1, 7'(i * 9)};
      load(w0, w1, w2, 2);
      chk("prescale", cfg.wdog_prescale_128, i[0]);
      chk("postscale", cfg.wdog_postscale_log2, {i[2:0], 1'b1});
      chk("two_speed", cfg.two_speed_startup_en, i[0]);
      chk("backup_bor", cfg.backup_supply_bor_en, i[1]);
      chk("alt_cmp", cfg.alt_cmp_ref_pins, i[2]);
      chk("alt_dac", cfg.alt_dac_ref_pins, i[2]);
      chk("alt_conv", cfg.alt_conv_ref_pins, i[1]);
      chk("init_osc", cfg.initial_osc, i);
      chk("clk_switch", cfg.clock_switch_en, !j[1]);
      chk("fail_safe", cfg.fail_safe_monitor_en, j == 2'h0);
      chk("clk_out", cfg.clock_output_en, j == 2'h0 || j == 2'h3);
      chk("prim_mode", cfg.primary_osc_mode, j);
      chk("win_mode", cfg.wdog_window_mode, 1);
      chk("win_width", cfg.wdog_window_eighths, win[j]);
      chk("seg_en", cfg.segment_protect_en, !j[0]);
      chk("bor", cfg.brownout_reset_en, 1);
      chk("sec_xtal", cfg.secondary_osc_crystal_en, 0);
      chk("low_page", cfg.protect_low_page, cwfd_pkg::PAGE_ZERO);
      chk("high_page", cfg.protect_high_page, 7'(i * 9));
      chk("cfg_prot", cfg.config_page_protected, !j[0]);
      chk("wclk_awake", cfg.wdog_clock, aw[j]);
      @(posedge pclk);
      sysclk_is_low_power_rc <= 1'b1;
      repeat (2) @(negedge pclk);
      chk("wclk_low_power_rc_osc_sys", cfg.wdog_clock, j == 2'h2 ? 1 : aw[j]);
      @(posedge pclk);
      sysclk_is_low_power_rc <= 1'b0;
      apb(1'b1, cwfd_pkg::ADDR_CTRL, 32'h00000001, rd, er);
      repeat (2) @(negedge pclk);
      chk("wclk_sleep", cfg.wdog_clock, sl[j]);
      apb(1'b0, cwfd_pkg::ADDR_CTRL, 32'h0, rd, er);
      chk("rd_ctrl", rd, 32'h00000001);
      apb(1'b1, cwfd_pkg::ADDR_CTRL, 32'h00000000, rd, er);
      apb(1'b0, cwfd_pkg::ADDR_WDOG, 32'h0, rd, er);
      chk("rd_wdog", rd, {8'h0, 8'hff, w0[15:0]});
      apb(1'b0, cwfd_pkg::ADDR_OSC, 32'h0, rd, er);
      chk("rd_osc", rd, {8'h0, 8'hff, w1[15:0]});
      apb(1'b0, cwfd_pkg::ADDR_PROT, 32'h0, rd, er);
      chk("rd_prot", rd, {8'h0, 8'hff, w2[15:0]});
    end
  endtask : t_sweep

  task automatic t_mux_off;
    logic [23:0] w2 [3];
    logic [41:0] snap;
    w2 = '{24'h00c9a0, 24'h0049d5, 24'h0049d4};
    for (int k = 0; k < 3; k++) begin
      load(24'h0000e0, 24'h004b2a, w2[k], 2);
      chk("cfg_prot_end", cfg.config_page_protected, k < 2);
    end
    load(24'h0000e0, 24'h004b2a, w2[0], 2);
    chk("wclk_mux_off", cfg.wdog_clock, 1);
    chk("win_off", cfg.wdog_window_mode, 0);
    chk("prescale0", cfg.wdog_prescale_128, 0);
    chk("postscale0", cfg.wdog_postscale_log2, 0);
    chk("clk_out_hs", cfg.clock_output_en, 0);
    chk("low_page_end", cfg.protect_low_page, 7'h20);
    chk("sec_xtal1", cfg.secondary_osc_crystal_en, 1);
    chk("bor0", cfg.brownout_reset_en, 0);
    snap = cfg;
    @(posedge pclk);
    flash_rvalid <= 1'b1;
    flash_rdata  <= 24'h000000;
    repeat (4) @(posedge pclk);
    flash_rvalid <= 1'b0;
    apb(1'b1, cwfd_pkg::ADDR_WDOG, 32'h00000000, rd, er);
    chk("wr_ro_err", er, 0);
    @(negedge pclk);
    chk("cfg_stable", cfg, snap);
    apb(1'b0, cwfd_pkg::ADDR_WDOG, 32'h0, rd, er);
    chk("rd_after_wr", rd, 32'h00ff00e0);
    apb(1'b0, cwfd_pkg::ADDR_STAT, 32'h0, rd, er);
    chk("status", rd, 32'h00000001);
    apb(1'b0, 12'h014, 32'h0, rd, er);
    chk("unmapped_err", er, 1);
    chk("unmapped_rd", rd, 0);
  endtask : t_mux_off

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    presetn                = 1'b0;
    psel                   = 1'b0;
    penable                = 1'b0;
    pwrite                 = 1'b0;
    paddr                  = 12'h000;
    pwdata                 = 32'h0;
    flash_rdata            = 24'h0;
    flash_rvalid           = 1'b0;
    sysclk_is_low_power_rc = 1'b0;
    n_errors               = 0;
    check_count            = 0;
    load(cwfd_pkg::ERASED, cwfd_pkg::ERASED, cwfd_pkg::ERASED, 12);
    t_sweep();
    t_mux_off();
    final_report();
  end

  initial begin
    #200000;
    n_errors++;
    final_report();
  end

endmodule : cwfd_decoder_tb
